// *** logic/power_mode_control.sv ***
// Power-mode controller: standby, measurement, settle and auto-sleep sequencing.
// Assumes a serial front end presents one-cycle register read/write strobes on clk.
`timescale 1ns/1ns
`default_nettype none
module power_mode_control #(
	parameter int SETTLE_CYCLES = pwr_mode_pkg::SETTLE_CYC,
	parameter int BASE_CYCLES = pwr_mode_pkg::BASE_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic inactivity_seen,
	input wire logic activity_seen,
	output logic sample_tick,
	output logic sampling_on,
	output logic data_valid,
	output logic reduced_sampling,
	output logic [3:0] active_rate,
	output logic asleep,
	output logic fifo_hold,
	output pwr_mode_pkg::pm_state_t mode
);
	import pwr_mode_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] inact_thresh_ff;
	logic [7:0] inact_dur_ff;
	logic [7:0] rate_cfg_ff;
	logic [7:0] power_control_ff;
	pm_state_t state_ff;
	pm_state_t nxt_state;
	logic [CNT_W-1:0] settle_ff;
	logic settle_done_ff;
	logic tick;
	logic run;
	logic div_run;
	logic measure_en;
	logic auto_sleep_en;
	logic [3:0] cur_rate;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction : hit

	assign measure_en = power_control_ff[MEASURE_BIT];
	assign auto_sleep_en = power_control_ff[AUTO_SLEEP_BIT] && power_control_ff[LINK_BIT];

	// Register writes accepted in every mode, standby included
	always_ff @(posedge clk) begin
		if (rst) begin
			inact_thresh_ff <= RST_INACT_THRESH;
		end else if (reg_wr && hit(reg_addr, ADDR_INACT_THRESH)) begin
			inact_thresh_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			inact_dur_ff <= RST_INACT_DUR;
		end else if (reg_wr && hit(reg_addr, ADDR_INACT_DUR)) begin
			inact_dur_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rate_cfg_ff <= RST_RATE_CFG;
		end else if (reg_wr && hit(reg_addr, ADDR_RATE_CFG)) begin
			rate_cfg_ff <= reg_wdata & RATE_CFG_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			power_control_ff <= RST_POWER_CONTROL;
		end else if (reg_wr && hit(reg_addr, ADDR_POWER_CONTROL)) begin
			power_control_ff <= reg_wdata & POWER_CONTROL_MASK;
		end
	end

	// Unmapped addresses read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					ADDR_INACT_THRESH: reg_rdata <= inact_thresh_ff;
					ADDR_INACT_DUR: reg_rdata <= inact_dur_ff;
					ADDR_RATE_CFG: reg_rdata <= rate_cfg_ff;
					ADDR_POWER_CONTROL: reg_rdata <= power_control_ff;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			PM_STANDBY: begin
				if (measure_en) begin
					nxt_state = PM_SETTLE;
				end
			end
			PM_SETTLE: begin
				if (!measure_en) begin
					nxt_state = PM_STANDBY;
				end else if (settle_done_ff && tick) begin
					nxt_state = PM_MEASURE;
				end
			end
			PM_MEASURE: begin
				if (!measure_en) begin
					nxt_state = PM_STANDBY;
				end else if (auto_sleep_en && inactivity_seen) begin
					nxt_state = PM_SLEEP;
				end
			end
			PM_SLEEP: begin
				if (!measure_en) begin
					nxt_state = PM_STANDBY;
				end else if (!auto_sleep_en || activity_seen) begin
					// Wake pays the same settle as a fresh enable
					nxt_state = PM_SETTLE;
				end
			end
			default: nxt_state = PM_STANDBY;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= PM_STANDBY;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Fixed 1.1 ms settle, then wait for one full sample tick
	always_ff @(posedge clk) begin
		if (rst || state_ff != PM_SETTLE) begin
			settle_ff <= '0;
			settle_done_ff <= 1'b0;
		end else if (settle_ff >= CNT_W'(SETTLE_CYCLES - 1)) begin
			settle_done_ff <= 1'b1;
		end else begin
			settle_ff <= settle_ff + CNT_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Sampling rate
	// ----------------------------------------------------------------
	// Sleep caps rate below 12.5 Hz; slower user codes are kept
	always_comb begin
		cur_rate = rate_cfg_ff[RATE_LSB +: RATE_W];
		if (state_ff == PM_SLEEP && cur_rate > RATE_SLEEP) begin
			cur_rate = RATE_SLEEP;
		end
	end

	assign run = (state_ff != PM_STANDBY);
	// Divider held during settle, so a full period follows it
	assign div_run = run && (state_ff != PM_SETTLE || settle_done_ff);

	sample_tick_gen #(
		.BASE_CYC(BASE_CYCLES),
		.CW(CNT_W)
	) u_tick (
		.clk(clk),
		.rst(rst),
		.run(div_run),
		.rate_code(cur_rate),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			sample_tick <= 1'b0;
			sampling_on <= 1'b0;
			data_valid <= 1'b0;
			reduced_sampling <= 1'b0;
			active_rate <= RST_RATE_CFG[RATE_LSB +: RATE_W];
			asleep <= 1'b0;
			fifo_hold <= 1'b1;
			mode <= PM_STANDBY;
		end else begin
			sample_tick <= tick && (state_ff == PM_MEASURE || state_ff == PM_SLEEP);
			sampling_on <= run;
			data_valid <= (state_ff == PM_MEASURE || state_ff == PM_SLEEP);
			// Flag follows bit 4 outside standby; useful codes are the host's duty
			reduced_sampling <= rate_cfg_ff[REDUCED_BIT] && run;
			active_rate <= cur_rate;
			asleep <= (state_ff == PM_SLEEP);
			// FIFO told to keep contents, never flushed by standby
			fifo_hold <= (state_ff == PM_STANDBY);
			mode <= state_ff;
		end
	end

endmodule : power_mode_control
`default_nettype wire

// *** shared/pwr_mode_pkg.sv ***
// Power-mode controller constants: register map, field positions, timing.
// Assumes a 25 MHz system clock and an 8-bit register port from the serial front end.
package pwr_mode_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_INACT_THRESH = 8'h25;
	localparam logic [7:0] ADDR_INACT_DUR = 8'h26;
	localparam logic [7:0] ADDR_RATE_CFG = 8'h2C;
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h2D;

	localparam logic [7:0] RST_INACT_THRESH = 8'h00;
	localparam logic [7:0] RST_INACT_DUR = 8'h00;
	localparam logic [7:0] RST_RATE_CFG = 8'h0A;
	localparam logic [7:0] RST_POWER_CONTROL = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RATE_LSB = 0;
	localparam int RATE_W = 4;
	localparam int REDUCED_BIT = 4;
	localparam int MEASURE_BIT = 3;
	localparam int AUTO_SLEEP_BIT = 4;
	localparam int LINK_BIT = 5;
	localparam logic [7:0] RATE_CFG_MASK = 8'h1F;
	localparam logic [7:0] POWER_CONTROL_MASK = 8'h38;

	// Rate codes
	localparam logic [3:0] RATE_MAX = 4'hF;
	localparam logic [3:0] RATE_SLEEP = 4'h6;
	localparam logic [3:0] RATE_LP_MIN = 4'h7;
	localparam logic [3:0] RATE_LP_MAX = 4'hC;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int TOP_RATE_HZ = 3200;
	// Period at code 1111 in clocks; lower codes double it
	localparam int BASE_PERIOD_CYC = CLK_HZ / TOP_RATE_HZ;
	localparam int SETTLE_US = 1100;
	localparam int SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1_000_000));
	localparam int CNT_W = 32;

	typedef enum logic [1:0] {
		PM_STANDBY,
		PM_SETTLE,
		PM_MEASURE,
		PM_SLEEP
	} pm_state_t;

endpackage : pwr_mode_pkg

// *** logic/sample_tick_gen.sv ***
// Sample-tick divider: one-cycle pulse per output sample period.
// Assumes the rate code is stable except at tick boundaries (sampled there).
`timescale 1ns/1ns
`default_nettype none
module sample_tick_gen #(
	parameter int BASE_CYC = pwr_mode_pkg::BASE_PERIOD_CYC,
	parameter int CW = pwr_mode_pkg::CNT_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [3:0] rate_code,
	output logic tick
);
	import pwr_mode_pkg::*;

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] period_ff;

	function automatic logic [CW-1:0] period_of(input logic [3:0] code);
		logic [CW-1:0] base;
		base = CW'(BASE_CYC);
		period_of = base << (RATE_MAX - code);
	endfunction : period_of

	// ----------------------------------------------------------------
	// Divider; new code is latched at a period boundary, and every cycle while stopped
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			cnt_ff <= '0;
			period_ff <= period_of(rate_code);
		end else if (cnt_ff >= period_ff - CW'(1)) begin
			cnt_ff <= '0;
			period_ff <= period_of(rate_code);
		end else begin
			cnt_ff <= cnt_ff + CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tick <= 1'b0;
		end else begin
			tick <= run && (cnt_ff >= period_ff - CW'(1));
		end
	end

endmodule : sample_tick_gen
`default_nettype wire

// *** tb/pmc_sva.sv ***
// Port checker for power_mode_control.
// Assumes binding to the design; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module pmc_sva #(
	parameter int SETTLE_CYCLES = pwr_mode_pkg::SETTLE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rvalid,
	input wire logic sample_tick,
	input wire logic sampling_on,
	input wire logic data_valid,
	input wire logic reduced_sampling,
	input wire logic [3:0] active_rate,
	input wire logic asleep,
	input wire logic fifo_hold,
	input wire pwr_mode_pkg::pm_state_t mode
);
	import pwr_mode_pkg::*;
	int settle_cnt_ff;
	// Cycles spent settling since the last standby or sleep
	always_ff @(posedge clk) begin
		if (rst || mode == PM_STANDBY || mode == PM_SLEEP) begin
			settle_cnt_ff <= 0;
		end else if (mode == PM_SETTLE) begin
			settle_cnt_ff <= settle_cnt_ff + 1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_meas_on;
		reg_wr && reg_addr == ADDR_POWER_CONTROL && reg_wdata[MEASURE_BIT] && mode == PM_STANDBY;
	endsequence
	sequence s_meas_off;
		reg_wr && reg_addr == ADDR_POWER_CONTROL && !reg_wdata[MEASURE_BIT];
	endsequence
	property p_idle;
		mode == PM_STANDBY |-> fifo_hold && !sampling_on && !data_valid && !reduced_sampling;
	endproperty
	property p_rd;
		reg_rd |=> reg_rvalid;
	endproperty
	property p_meas_on;
		s_meas_on |-> ##[1:3] mode == PM_SETTLE;
	endproperty
	property p_meas_off;
		s_meas_off |-> ##[1:3] mode == PM_STANDBY;
	endproperty
	property p_no_tick;
		(mode == PM_STANDBY) [*3] |-> !sample_tick;
	endproperty
	property p_settle;
		$rose(data_valid) |-> settle_cnt_ff >= SETTLE_CYCLES;
	endproperty
	property p_sleep_rate;
		asleep |-> active_rate <= RATE_SLEEP;
	endproperty
	property p_asleep;
		asleep == (mode == PM_SLEEP);
	endproperty
	a_idle: assert property (p_idle) else $error("standby outputs wrong");
	a_rd: assert property (p_rd) else $error("read not answered");
	a_meas_on: assert property (p_meas_on) else $error("no settle after enable");
	a_meas_off: assert property (p_meas_off) else $error("no standby after clear");
	a_no_tick: assert property (p_no_tick) else $error("tick in standby");
	a_settle: assert property (p_settle) else $error("valid before settle");
	a_sleep_rate: assert property (p_sleep_rate) else $error("sleep rate too high");
	a_asleep: assert property (p_asleep) else $error("asleep disagrees with mode");
endmodule : pmc_sva
bind power_mode_control pmc_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) pmc_sva_u (
	.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .sample_tick(sample_tick),
	.sampling_on(sampling_on), .data_valid(data_valid), .reduced_sampling(reduced_sampling),
	.active_rate(active_rate), .asleep(asleep), .fifo_hold(fifo_hold), .mode(mode));
`default_nettype wire

// *** tb/host_model.sv ***
// Host model: single-byte register writes and reads.
// Assumes one call at a time, launched from the bench.
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Released bus shows the inverse, never a stale copy
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
	endtask : rd
endmodule : host_model
`default_nettype wire

// *** tb/test_power_mode_control.sv ***
// Bench for power_mode_control driven by the host model.
// Assumes short settle (20) and base period (4) parameters.
`timescale 1ns/1ns
`default_nettype none
module test_power_mode_control;
	import pwr_mode_pkg::*;
	localparam int BASE = 4;
	localparam int SETTLE = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic inact = 1'b0;
	logic act = 1'b0;
	logic reg_wr, reg_rd, reg_rvalid, sample_tick, sampling_on, data_valid;
	logic reduced_sampling, asleep, fifo_hold;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [3:0] active_rate;
	pwr_mode_pkg::pm_state_t mode;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	always #20 clk = ~clk;
	host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata));
	power_mode_control #(.SETTLE_CYCLES(SETTLE), .BASE_CYCLES(BASE)) dut_u (.clk(clk), .rst(rst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .inactivity_seen(inact),
		.activity_seen(act), .sample_tick(sample_tick), .sampling_on(sampling_on),
		.data_valid(data_valid), .reduced_sampling(reduced_sampling), .active_rate(active_rate),
		.asleep(asleep), .fifo_hold(fifo_hold), .mode(mode));
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task rd(input logic [7:0] a, input logic [7:0] exp);
		host_u.rd(a);
		#1;
		chk("rvalid", 8'(reg_rvalid), 8'h01);
		chk("rdata", reg_rdata, exp);
	endtask : rd
	task t_reset;
		rd(ADDR_INACT_THRESH, RST_INACT_THRESH);
		rd(ADDR_RATE_CFG, RST_RATE_CFG);
		rd(ADDR_POWER_CONTROL, RST_POWER_CONTROL);
		chk("mode", 8'(mode), 8'(PM_STANDBY));
		chk("rate", 8'(active_rate), 8'h0A);
	endtask : t_reset
	task t_regs;
		host_u.wr(ADDR_INACT_THRESH, 8'h11);
		host_u.wr(ADDR_INACT_DUR, 8'h22);
		host_u.wr(ADDR_RATE_CFG, 8'hFF);
		host_u.wr(ADDR_POWER_CONTROL, 8'hF7);
		host_u.wr(8'h2E, 8'h55);
		rd(ADDR_INACT_THRESH, 8'h11);
		rd(ADDR_INACT_DUR, 8'h22);
		rd(ADDR_RATE_CFG, RATE_CFG_MASK);
		rd(ADDR_POWER_CONTROL, 8'h30);
		rd(8'h2E, 8'h00);
		chk("mode", 8'(mode), 8'(PM_STANDBY));
		host_u.wr(ADDR_RATE_CFG, RST_RATE_CFG);
	endtask : t_regs
	task t_measure;
		host_u.wr(ADDR_POWER_CONTROL, 8'h08);
		n = 0;
		while (data_valid !== 1'b1 && n < 9000) begin
			@(posedge clk);
			#1;
			n++;
		end
		// Settle, then one full period at code 1010, plus register latency
		chk("settle", 8'((n - SETTLE - (BASE << 5)) inside {[0:4]}), 8'h01);
		chk("mode", 8'(mode), 8'(PM_MEASURE));
		chk("sampling_on", 8'(sampling_on), 8'h01);
	endtask : t_measure
	task t_rates;
		for (int c = 15; c >= 11; c--) begin
			host_u.wr(ADDR_RATE_CFG, 8'(c));
			@(posedge sample_tick);
			@(posedge sample_tick);
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (sample_tick !== 1'b1);
			chk("period", 8'(n), 8'(BASE << (15 - c)));
			chk("rate", 8'(active_rate), 8'(c));
		end
	endtask : t_rates
	task t_low;
		host_u.wr(ADDR_RATE_CFG, 8'h1C);
		n = 0;
		while (reduced_sampling !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("reduced", 8'(reduced_sampling), 8'h01);
		rd(ADDR_RATE_CFG, 8'h1C);
	endtask : t_low
	task t_sleep;
		host_u.wr(ADDR_POWER_CONTROL, 8'h38);
		inact <= 1'b1;
		n = 0;
		while (asleep !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("asleep", 8'(asleep), 8'h01);
		chk("sleep_rate", 8'(active_rate), 8'(RATE_SLEEP));
		@(posedge clk);
		inact <= 1'b0;
		act <= 1'b1;
		n = 0;
		while (mode !== PM_MEASURE && n < 6000) begin
			@(posedge clk);
			#1;
			n++;
		end
		// Wake at code 1100: settle plus one full period
		chk("wake", 8'((n - SETTLE - (BASE << 3)) inside {[0:4]}), 8'h01);
		@(posedge clk);
		act <= 1'b0;
	endtask : t_sleep
	task t_standby;
		host_u.wr(ADDR_POWER_CONTROL, 8'h00);
		repeat (4) @(posedge clk);
		#1;
		chk("mode", 8'(mode), 8'(PM_STANDBY));
		chk("fifo_hold", 8'(fifo_hold), 8'h01);
		chk("data_valid", 8'(data_valid), 8'h00);
		n = 0;
		repeat (70) begin
			@(posedge clk);
			#1;
			n += int'(sample_tick === 1'b1);
		end
		chk("ticks", 8'(n), 8'h00);
		rd(ADDR_INACT_DUR, 8'h22);
	endtask : t_standby
	task wrap_up;
		if (mismatches == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			wrap_up;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_regs;
		t_measure;
		t_rates;
		t_low;
		t_sleep;
		t_standby;
		wrap_up;
	end
endmodule : test_power_mode_control
`default_nettype wire
